// file: hw/fcs_sequencer.sv
/*
  fcs_sequencer: command front end of an on-chip flash array. decodes
  unlock-prefixed bus writes, runs program/erase/protect operations and
  returns status, identification or array data on reads.
  assumes bus writes and reads are one-cycle strobes synchronous to CORE_CLK;
  read data appears two cycles after the read strobe with RD_VALID.
*/
// Functional notes
// R1 - each command starts with AAh at AAAh, 55h at 554h, command at AAAh
// R2 - host keeps all sequence addresses inside the flash region
// R3 - A0h: fourth write programs one word, done within 60 us
// R4 - host gives an even word address for programming
// R5 - 80h, prefix, 30h at sector address erases that 4-Kbyte sector in 75 ms
// R6 - host issues no sector erase in external programmer mode
// R7 - 80h, prefix, 10h at AAAh erases the whole array in 300 ms
// R8 - erased words read FFFFh
// R9 - writes are ignored while an operation runs
// R10 - bit 6 inverts on each read during an operation
// R11 - bit 7 reads 0 during erase; undefined during protection set
// R12 - only bits 7 and 6 are defined in status reads
// R13 - host polls one address until two reads match
// R14 - identification entry returns vendor, macro, size and protection codes
// R15 - array data is hidden in identification mode
// R16 - identification exits by lone F0h write or prefix plus F0h
// R17 - A5h then F0h at 77Eh sets read protection
// R18 - A5h then 0Fh at 77Eh sets write protection
// R19 - host has the protection location programmed with 00h
// R20 - protection set takes 60 us; only chip erase clears it (here RST also clears both protection flags)
// R21 - identification read at 77Eh shows protection bits
// R22 - host erases before reprogramming a written word
// R23 - bit 7 reads complement of programmed bit 7 while programming
// R24 - first status read after an operation starts shows bit 6 as 1
// R25 - a mismatched step returns to array read with no operation
// R26 - reset gives array read, no operation, identification off
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer #(
  parameter int CYC_SECT = fcs_pkg::CYC_SECT,
  parameter int CYC_CHIP = fcs_pkg::CYC_CHIP,
  parameter logic [15:0] VENDOR_CODE = 16'h005a,  // arbitrary value
  parameter logic [15:0] MACRO_CODE  = 16'h00a1,  // arbitrary value
  parameter logic [15:0] SIZE_CODE   = 16'h0011   // arbitrary value
) (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RST,
  input  wire logic                        WR_STB,
  input  wire logic                        RD_STB,
  input  wire logic [fcs_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [fcs_pkg::DATA_W-1:0]  WDATA,
  output logic      [fcs_pkg::DATA_W-1:0]  RDATA,
  output logic                             RD_VALID,
  output logic                             BUSY,
  output logic                             ID_MODE,
  output logic                             READ_PROTECTED,
  output logic                             WRITE_PROTECTED
);
  typedef enum {S_IDLE, S_U1, S_U2, S_CMD_PROG, S_CMD_ERASE, S_E1, S_E2,
                S_CMD_PROT, S_BUSY} fcs_state_t;

  fcs_state_t                     state;
  fcs_pkg::fcs_op_t               op;
  logic [fcs_pkg::ARRAY_AW-1:0]   prog_addr;
  logic [fcs_pkg::DATA_W-1:0]     program_word_value;
  logic [fcs_pkg::ARRAY_AW-1:0]   sweep_addr;
  logic [fcs_pkg::ARRAY_AW-1:0]   sweep_end;
  logic                           sweeping;
  logic                           alternating_status_bit;
  logic                           rd_pend;
  logic [fcs_pkg::ADDR_W-1:0]     rd_addr;
  logic                           pend_rd_prot;
  logic                           pend_wr_prot;
  logic                           tmr_load;
  logic [fcs_pkg::CNT_W-1:0]      tmr_count;
  logic                           tmr_busy;
  logic                           tmr_done;
  logic                           mem_we;
  logic [fcs_pkg::ARRAY_AW-1:0]   mem_waddr;
  logic [fcs_pkg::DATA_W-1:0]     mem_wdata;
  logic [fcs_pkg::DATA_W-1:0]     mem_rdata;
  logic [fcs_pkg::ARRAY_AW-1:0]   word_index;

  function automatic logic step_ok(input logic [fcs_pkg::ADDR_W-1:0] a,
                                   input logic [fcs_pkg::DATA_W-1:0] d,
                                   input logic [11:0] ofs,
                                   input logic [7:0] val);
    step_ok = (a[11:0] == ofs) && (d[7:0] == val);
  endfunction : step_ok

  function automatic logic [fcs_pkg::ARRAY_AW-1:0] to_word(input logic [fcs_pkg::ADDR_W-1:0] a);
    to_word = a[fcs_pkg::ARRAY_AW:1];
  endfunction : to_word

  assign word_index = to_word(ADDR);

  // command decode
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state        <= S_IDLE; // R26
      op           <= fcs_pkg::OP_NONE;
      ID_MODE      <= 1'b0;
      tmr_load     <= 1'b0;
      tmr_count    <= '0;
      prog_addr    <= '0;
      program_word_value <= '0;
      pend_rd_prot <= 1'b0;
      pend_wr_prot <= 1'b0;
    end else begin
      tmr_load <= 1'b0;
      case (state)
        S_BUSY: begin
          if (tmr_done) begin
            state <= S_IDLE;
            op    <= fcs_pkg::OP_NONE;
          end
        end
        default: begin
          if (WR_STB) begin
            state <= S_IDLE; // R25
            case (state)
              S_IDLE: begin
                if (step_ok(ADDR, WDATA, fcs_pkg::OFS_UNLOCK1, fcs_pkg::DAT_UNLOCK1)) begin
                  state <= S_U1; // R1
                end else if (ID_MODE && WDATA[7:0] == fcs_pkg::CMD_ID_OUT) begin
                  ID_MODE <= 1'b0; // R16
                end
              end
              S_U1: begin
                if (step_ok(ADDR, WDATA, fcs_pkg::OFS_UNLOCK2, fcs_pkg::DAT_UNLOCK2)) begin
                  state <= S_U2; // R1
                end
              end
              S_U2: begin
                if (ADDR[11:0] == fcs_pkg::OFS_UNLOCK1) begin
                  if (WDATA[7:0] == fcs_pkg::CMD_PROGRAM) begin
                    state <= S_CMD_PROG;
                  end else if (WDATA[7:0] == fcs_pkg::CMD_ERASE) begin
                    state <= S_CMD_ERASE;
                  end else if (WDATA[7:0] == fcs_pkg::CMD_PROTECT) begin
                    state <= S_CMD_PROT;
                  end else if (WDATA[7:0] == fcs_pkg::CMD_ID_IN) begin
                    ID_MODE <= 1'b1; // R14
                  end else if (WDATA[7:0] == fcs_pkg::CMD_ID_OUT) begin
                    ID_MODE <= 1'b0; // R16
                  end
                end
              end
              S_CMD_PROG: begin
                prog_addr          <= word_index; // R3
                program_word_value <= WDATA;
                op        <= fcs_pkg::OP_PROG;
                tmr_count <= fcs_pkg::CNT_W'(fcs_pkg::CYC_PROG);
                tmr_load  <= 1'b1;
                state     <= S_BUSY;
              end
              S_CMD_ERASE: begin
                if (step_ok(ADDR, WDATA, fcs_pkg::OFS_UNLOCK1, fcs_pkg::DAT_UNLOCK1)) begin
                  state <= S_E1;
                end
              end
              S_E1: begin
                if (step_ok(ADDR, WDATA, fcs_pkg::OFS_UNLOCK2, fcs_pkg::DAT_UNLOCK2)) begin
                  state <= S_E2;
                end
              end
              S_E2: begin
                if (WDATA[7:0] == fcs_pkg::CMD_SECTOR) begin
                  prog_addr <= word_index; // R5
                  op        <= fcs_pkg::OP_SECT;
                  tmr_count <= fcs_pkg::CNT_W'(CYC_SECT);
                  tmr_load  <= 1'b1;
                  state     <= S_BUSY;
                end else if (step_ok(ADDR, WDATA, fcs_pkg::OFS_UNLOCK1, fcs_pkg::CMD_CHIP)) begin
                  op        <= fcs_pkg::OP_CHIP; // R7
                  tmr_count <= fcs_pkg::CNT_W'(CYC_CHIP);
                  tmr_load  <= 1'b1;
                  state     <= S_BUSY;
                end
              end
              S_CMD_PROT: begin
                if (ADDR[11:0] == fcs_pkg::OFS_PROTECT &&
                    (WDATA[7:0] == fcs_pkg::DAT_RD_PROT || WDATA[7:0] == fcs_pkg::DAT_WR_PROT)) begin
                  pend_rd_prot <= (WDATA[7:0] == fcs_pkg::DAT_RD_PROT); // R17
                  pend_wr_prot <= (WDATA[7:0] == fcs_pkg::DAT_WR_PROT); // R18
                  op        <= fcs_pkg::OP_PROT;
                  tmr_count <= fcs_pkg::CNT_W'(fcs_pkg::CYC_PROG); // R20
                  tmr_load  <= 1'b1;
                  state     <= S_BUSY;
                end
              end
              default: begin
                state <= S_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // busy flag straight from a flop; writes in S_BUSY fall through untouched
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= (state == S_BUSY) && !tmr_done; // R9
    end
  end

  // protection flags, cleared only by chip erase or RST
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      READ_PROTECTED  <= 1'b0;
      WRITE_PROTECTED <= 1'b0;
    end else if (tmr_done && op == fcs_pkg::OP_PROT) begin
      READ_PROTECTED  <= READ_PROTECTED | pend_rd_prot;
      WRITE_PROTECTED <= WRITE_PROTECTED | pend_wr_prot;
    end else if (tmr_done && op == fcs_pkg::OP_CHIP) begin
      READ_PROTECTED  <= 1'b0; // R20
      WRITE_PROTECTED <= 1'b0;
    end
  end

  // array writes: one word program or an erase sweep at the end of the op
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sweeping   <= 1'b0;
      sweep_addr <= '0;
      sweep_end  <= '0;
    end else if (tmr_done && op == fcs_pkg::OP_SECT) begin
      sweeping   <= 1'b1;
      sweep_addr <= {prog_addr[fcs_pkg::ARRAY_AW-1:fcs_pkg::SECTOR_LO-1], {(fcs_pkg::SECTOR_LO-1){1'b0}}};
      sweep_end  <= {prog_addr[fcs_pkg::ARRAY_AW-1:fcs_pkg::SECTOR_LO-1], {(fcs_pkg::SECTOR_LO-1){1'b1}}};
    end else if (tmr_done && op == fcs_pkg::OP_CHIP) begin
      sweeping   <= 1'b1;
      sweep_addr <= '0;
      sweep_end  <= '1;
    end else if (sweeping) begin
      sweep_addr <= sweep_addr + 1'b1;
      sweeping   <= (sweep_addr != sweep_end);
    end
  end

  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = prog_addr;
    mem_wdata = program_word_value;
    if (sweeping) begin
      mem_we    = 1'b1;
      mem_waddr = sweep_addr;
      mem_wdata = fcs_pkg::ERASED_WORD; // R8
    end else if (tmr_done && op == fcs_pkg::OP_PROG) begin
      mem_we    = 1'b1;
      mem_wdata = program_word_value & mem_rdata;
    end
  end

  fcs_array_mem u_mem (
    .clk   (CORE_CLK),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    // target word held on the read port while programming, so the merge sees it
    .raddr ((tmr_busy && op == fcs_pkg::OP_PROG) ? prog_addr : word_index),
    .rdata (mem_rdata)
  );

  fcs_op_timer u_timer (
    .clk   (CORE_CLK),
    .rst   (RST),
    .load  (tmr_load),
    .count (tmr_count),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // read path: status, identification or array data
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rd_pend  <= 1'b0;
      rd_addr  <= '0;
      RD_VALID <= 1'b0;
      RDATA    <= '0;
      alternating_status_bit <= 1'b1;
    end else begin
      rd_pend  <= RD_STB;
      RD_VALID <= rd_pend;
      if (RD_STB) begin
        rd_addr <= ADDR;
      end
      if (tmr_load) begin
        alternating_status_bit <= 1'b1; // R24
      end
      if (rd_pend) begin
        RDATA <= '0; // R12
        if (tmr_busy) begin
          RDATA[fcs_pkg::TOGGLE_BIT] <= alternating_status_bit; // R10
          alternating_status_bit     <= ~alternating_status_bit;
          if (op == fcs_pkg::OP_PROG) begin
            RDATA[fcs_pkg::POLL_BIT] <= ~program_word_value[fcs_pkg::POLL_BIT]; // R23
          end else begin
            RDATA[fcs_pkg::POLL_BIT] <= 1'b0; // R11
          end
        end else if (ID_MODE) begin
          if (rd_addr[11:0] == fcs_pkg::OFS_PROTECT) begin
            RDATA <= {14'h0000, WRITE_PROTECTED, READ_PROTECTED}; // R21
          end else if (rd_addr[2:1] == fcs_pkg::ID_VENDOR) begin
            RDATA <= VENDOR_CODE; // R15
          end else if (rd_addr[2:1] == fcs_pkg::ID_MACRO) begin
            RDATA <= MACRO_CODE;
          end else if (rd_addr[2:1] == fcs_pkg::ID_SIZE) begin
            RDATA <= SIZE_CODE;
          end
        end else begin
          RDATA <= mem_rdata;
        end
      end
    end
  end
endmodule : fcs_sequencer
`default_nettype wire

// file: hw/fcs_pkg.sv
/*
  fcs_pkg: constants for the flash command sequencer: unlock addresses and
  data, command bytes, status bit positions and operation timing.
  assumes a 100 MHz core clock; no imports anywhere, use fcs_pkg::name.
*/
package fcs_pkg;
  localparam int          ADDR_W      = 24;
  localparam int          DATA_W      = 16;
  localparam int          ARRAY_AW    = 16;
  localparam logic [11:0] OFS_UNLOCK1 = 12'haaa;
  localparam logic [11:0] OFS_UNLOCK2 = 12'h554;
  localparam logic [11:0] OFS_PROTECT = 12'h77e;
  localparam logic [7:0]  DAT_UNLOCK1 = 8'haa;
  localparam logic [7:0]  DAT_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM = 8'ha0;
  localparam logic [7:0]  CMD_ERASE   = 8'h80;
  localparam logic [7:0]  CMD_SECTOR  = 8'h30;
  localparam logic [7:0]  CMD_CHIP    = 8'h10;
  localparam logic [7:0]  CMD_ID_IN   = 8'h90;
  localparam logic [7:0]  CMD_ID_OUT  = 8'hf0;
  localparam logic [7:0]  CMD_PROTECT = 8'ha5;
  localparam logic [7:0]  DAT_RD_PROT = 8'hf0;
  localparam logic [7:0]  DAT_WR_PROT = 8'h0f;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int          POLL_BIT    = 7;
  localparam int          TOGGLE_BIT  = 6;
  localparam int          SECTOR_LO   = 12;
  localparam int          SECTOR_HI   = 23;
  // identification offsets (byte address bits [2:1])
  localparam logic [1:0]  ID_VENDOR   = 2'h0;
  localparam logic [1:0]  ID_MACRO    = 2'h1;
  localparam logic [1:0]  ID_SIZE     = 2'h2;
  localparam int          CLK_MHZ     = 100;
  localparam int          T_PROG_US   = 60;
  localparam int          T_SECT_MS   = 75;
  localparam int          T_CHIP_MS   = 300;
  localparam int          CYC_PROG    = T_PROG_US * CLK_MHZ;
  localparam int          CYC_SECT    = T_SECT_MS * 1000 * CLK_MHZ;
  localparam int          CYC_CHIP    = T_CHIP_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W       = 25;
  typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SECT, OP_CHIP, OP_PROT} fcs_op_t;
endpackage : fcs_pkg

// file: hw/fcs_array_mem.sv
/*
  fcs_array_mem: word array behind the sequencer with registered read data.
  assumes single clock; erase sweeps are driven one word per cycle by the owner.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_array_mem (
  input  wire logic                        clk,
  input  wire logic                        we,
  input  wire logic [fcs_pkg::ARRAY_AW-1:0] waddr,
  input  wire logic [fcs_pkg::DATA_W-1:0]   wdata,
  input  wire logic [fcs_pkg::ARRAY_AW-1:0] raddr,
  output logic      [fcs_pkg::DATA_W-1:0]   rdata
);
  logic [fcs_pkg::DATA_W-1:0] mem [0:(1<<fcs_pkg::ARRAY_AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : fcs_array_mem
`default_nettype wire

// file: hw/fcs_op_timer.sv
/*
  fcs_op_timer: down counter giving the run time of one automatic operation.
  assumes load is a single-cycle pulse while the timer is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_op_timer (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       load,
  input  wire logic [fcs_pkg::CNT_W-1:0]  count,
  output logic                            busy,
  output logic                            done
);
  logic [fcs_pkg::CNT_W-1:0] remain;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remain <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        remain <= count;
        busy   <= 1'b1;
      end else if (busy) begin
        if (remain <= {{(fcs_pkg::CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - {{(fcs_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule : fcs_op_timer
`default_nettype wire

// file: verification/fcs_seq_monitor.sv
/*
  fcs_seq_monitor: port assertions for the flash command sequencer.
  assumes it is bound into fcs_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_seq_monitor #(
  parameter int CYC_SECT = 50,
  parameter int CYC_CHIP = 80
) (
  input wire logic                         CORE_CLK,
  input wire logic                         RST,
  input wire logic                         WR_STB,
  input wire logic                         RD_STB,
  input wire logic [fcs_pkg::ADDR_W-1:0]   ADDR,
  input wire logic [fcs_pkg::DATA_W-1:0]   RDATA,
  input wire logic                         RD_VALID,
  input wire logic                         BUSY,
  input wire logic                         ID_MODE,
  input wire logic                         READ_PROTECTED,
  input wire logic                         WRITE_PROTECTED
);
  localparam int BUSY_MAX = fcs_pkg::CYC_PROG + CYC_SECT + CYC_CHIP + 4;
  logic [31:0] busy_cnt;
  logic [1:0]  busy_d;
  logic        last_tog;
  logic        last_stat;
  logic        first_rd;
  wire         stat_rd = RD_VALID && BUSY && busy_d[1];

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      busy_cnt <= '0;
      busy_d   <= '0;
    end else begin
      busy_cnt <= BUSY ? busy_cnt + 32'h1 : 32'h0;
      busy_d   <= {busy_d[0], BUSY};
    end
  end

  // remembers the last status read of the running operation
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      last_tog  <= 1'b0;
      last_stat <= 1'b0;
      first_rd  <= 1'b0;
    end else begin
      if (BUSY && !busy_d[0]) first_rd <= 1'b1;
      if (RD_VALID) begin
        last_stat <= stat_rd;
        last_tog  <= RDATA[fcs_pkg::TOGGLE_BIT];
        if (stat_rd) first_rd <= 1'b0;
      end
    end
  end

  rd_latency_a: assert property (RD_STB |-> ##2 RD_VALID)
    else $error("read answer not two cycles after strobe");
  rd_cause_a: assert property (RD_VALID |-> $past(RD_STB, 2))
    else $error("read valid without a read");
  rdata_hold_a: assert property (!RD_VALID |-> $stable(RDATA))
    else $error("read data moved between reads");
  busy_start_a: assert property ($rose(BUSY) |-> $past(WR_STB, 2))
    else $error("operation started without a write");
  busy_bound_a: assert property (busy_cnt <= BUSY_MAX)
    else $error("operation runs too long");
  status_bits_a: assert property (stat_rd |-> RDATA[15:8] == 8'h00 && RDATA[5:0] == 6'h00)
    else $error("undefined status bits not zero");
  toggle_flip_a: assert property (stat_rd && last_stat && !first_rd |-> RDATA[6] != last_tog)
    else $error("toggle bit did not alternate");
  toggle_first_a: assert property (stat_rd && first_rd |-> RDATA[6])
    else $error("first status read toggle bit not one");
  prot_report_a: assert property (RD_STB && ID_MODE && !BUSY && ADDR[11:0] == 12'h77e
    |-> ##2 RDATA[1:0] == {WRITE_PROTECTED, READ_PROTECTED})
    else $error("protection status read wrong");
  id_change_a: assert property ($changed(ID_MODE)
    |-> $past(WR_STB, 1) || $past(WR_STB, 2) || $past(WR_STB, 3))
    else $error("identification mode changed without a write");
endmodule : fcs_seq_monitor

bind fcs_sequencer fcs_seq_monitor #(.CYC_SECT(CYC_SECT), .CYC_CHIP(CYC_CHIP)) i_mon (
  .CORE_CLK(CORE_CLK), .RST(RST), .WR_STB(WR_STB), .RD_STB(RD_STB), .ADDR(ADDR),
  .RDATA(RDATA), .RD_VALID(RD_VALID), .BUSY(BUSY), .ID_MODE(ID_MODE),
  .READ_PROTECTED(READ_PROTECTED), .WRITE_PROTECTED(WRITE_PROTECTED));
`default_nettype wire

// file: verification/fcs_host_model.sv
/*
  fcs_host_model: bus master issuing sequencer write and read cycles.
  assumes strobes are sampled on the rising edge; drives on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_host_model (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RD_VALID,
  input  wire logic [fcs_pkg::DATA_W-1:0]  RDATA,
  output logic                             WR_STB,
  output logic                             RD_STB,
  output logic      [fcs_pkg::ADDR_W-1:0]  ADDR,
  output logic      [fcs_pkg::DATA_W-1:0]  WDATA
);
  initial begin
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    ADDR   = 24'h000000;
    WDATA  = 16'h0000;
  end

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(negedge CORE_CLK);
    WR_STB = 1'b1;
    ADDR   = a;
    WDATA  = d;
    @(negedge CORE_CLK);
    WR_STB = 1'b0;
    // released lines show the inverse
    ADDR   = ~a;
    WDATA  = ~d;
  endtask : wr

  task automatic seq(input logic [23:0] a, input logic [7:0] c);
    wr(24'h000aaa, 16'h00aa);
    wr(24'h000554, 16'h0055);
    wr(a, {8'h00, c});
  endtask : seq

  task automatic rd(input logic [23:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d  = 16'h0000;
    @(negedge CORE_CLK);
    RD_STB = 1'b1;
    ADDR   = a;
    @(negedge CORE_CLK);
    RD_STB = 1'b0;
    ADDR   = ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge CORE_CLK);
      if (RD_VALID === 1'b1) begin
        ok = 1'b1;
        d  = RDATA;
      end
    end
  endtask : rd
endmodule : fcs_host_model
`default_nettype wire

// file: verification/tb_flash_command_sequencer.sv
/*
  tb_flash_command_sequencer: command sequences with expected results.
  assumes short erase timer parameters and the host model as bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_flash_command_sequencer;
  localparam logic [23:0] A1 = 24'h000aaa;
  logic        CORE_CLK = 1'b0;
  logic        RST      = 1'b1;
  logic        WR_STB;
  logic        RD_STB;
  logic [23:0] ADDR;
  logic [15:0] WDATA;
  logic [15:0] RDATA;
  logic        RD_VALID;
  logic        BUSY;
  logic        ID_MODE;
  logic        READ_PROTECTED;
  logic        WRITE_PROTECTED;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  fcs_sequencer #(.CYC_SECT(50), .CYC_CHIP(80)) i_dut (
    .CORE_CLK(CORE_CLK), .RST(RST), .WR_STB(WR_STB), .RD_STB(RD_STB), .ADDR(ADDR),
    .WDATA(WDATA), .RDATA(RDATA), .RD_VALID(RD_VALID), .BUSY(BUSY), .ID_MODE(ID_MODE),
    .READ_PROTECTED(READ_PROTECTED), .WRITE_PROTECTED(WRITE_PROTECTED));

  fcs_host_model i_host (
    .CORE_CLK(CORE_CLK), .RD_VALID(RD_VALID), .RDATA(RDATA), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .ADDR(ADDR), .WDATA(WDATA));

  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rchk(input logic [23:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    i_host.rd(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      report_and_stop();
    end else begin
      check(d & m, e);
    end
  endtask : rchk

  task automatic settle();
    repeat (3) @(negedge CORE_CLK);
  endtask : settle

  // flag order: busy, id mode, read protect, write protect
  task automatic flags(input logic [3:0] e);
    check({12'h000, BUSY, ID_MODE, READ_PROTECTED, WRITE_PROTECTED}, {12'h000, e});
  endtask : flags

  task automatic idle(input int lim);
    settle();
    for (int i = 0; i < lim; i++) begin
      @(negedge CORE_CLK);
      if (BUSY === 1'b0) return;
    end
    n_mismatch++;
    report_and_stop();
  endtask : idle

  initial begin
    repeat (5) @(negedge CORE_CLK);
    RST = 1'b0;
    settle();
    flags(4'h0);
    i_host.seq(A1, 8'h90);
    settle();
    flags(4'h4);
    rchk(24'h000000, 16'hffff, 16'h005a);
    rchk(24'h000002, 16'hffff, 16'h00a1);
    rchk(24'h000004, 16'hffff, 16'h0011);
    rchk(24'h00077e, 16'h0003, 16'h0000);
    i_host.wr(24'h123456, 16'h00f0);
    settle();
    flags(4'h0);
    i_host.seq(A1, 8'h90);
    i_host.seq(A1, 8'hf0);
    settle();
    flags(4'h0);
    i_host.seq(A1, 8'ha5);
    i_host.wr(24'h00077e, 16'h00f0);
    settle();
    flags(4'h8);
    rchk(24'h00077e, 16'hff7f, 16'h0040);
    rchk(24'h00077e, 16'h0040, 16'h0000);
    rchk(24'h00077e, 16'h0040, 16'h0040);
    i_host.seq(A1, 8'h90);
    idle(7000);
    flags(4'h2);
    i_host.seq(A1, 8'ha5);
    i_host.wr(24'h00077e, 16'h000f);
    idle(7000);
    flags(4'h3);
    i_host.seq(A1, 8'h90);
    settle();
    rchk(24'h000100, 16'hffff, 16'h005a);
    rchk(24'h00077e, 16'h0003, 16'h0003);
    i_host.wr(24'h000000, 16'h00f0);
    i_host.wr(A1, 16'h00aa);
    i_host.wr(24'h000554, 16'h0056);
    i_host.wr(A1, 16'h00a0);
    i_host.wr(24'h000100, 16'h1234);
    settle();
    flags(4'h3);
    i_host.seq(A1, 8'h80);
    i_host.seq(A1, 8'h10);
    settle();
    rchk(24'h000100, 16'h00c0, 16'h0040);
    idle(200);
    repeat (65600) @(negedge CORE_CLK);
    flags(4'h0);
    rchk(24'h000100, 16'hffff, 16'hffff);
    rchk(24'h01fffe, 16'hffff, 16'hffff);
    i_host.seq(A1, 8'ha0);
    i_host.wr(24'h000100, 16'h1234);
    settle();
    rchk(24'h000100, 16'h00c0, 16'h00c0);
    rchk(24'h000100, 16'h0040, 16'h0000);
    i_host.seq(A1, 8'ha0);
    i_host.wr(24'h001000, 16'h5678);
    idle(7000);
    rchk(24'h000100, 16'hffff, 16'h1234);
    rchk(24'h001000, 16'hffff, 16'hffff);
    i_host.seq(A1, 8'ha0);
    i_host.wr(24'h001000, 16'h5678);
    idle(7000);
    rchk(24'h001000, 16'hffff, 16'h5678);
    i_host.seq(A1, 8'h80);
    i_host.seq(24'h001000, 8'h30);
    idle(200);
    repeat (2100) @(negedge CORE_CLK);
    rchk(24'h001000, 16'hffff, 16'hffff);
    rchk(24'h000100, 16'hffff, 16'h1234);
    i_host.seq(A1, 8'h90);
    settle();
    flags(4'h4);
    RST = 1'b1;
    repeat (5) @(negedge CORE_CLK);
    RST = 1'b0;
    settle();
    flags(4'h0);
    report_and_stop();
  end
endmodule : tb_flash_command_sequencer
`default_nettype wire
